// [src/cxu_params.svh]
// constants of the context exchange unit: timing counts, opcodes, field positions
`ifndef CXU_PARAMS_SVH
`define CXU_PARAMS_SVH
`define CXU_SWAP_CPS 6'h24
`define CXU_FETCH_CPS 6'h0E
`define CXU_XA_RST 8'h00
`define CXU_MODE_RST 5'h00
`define CXU_FLAG_RST 9'h000
`define CXU_OP_ERR_EXIT 7'h00
`define CXU_OP_NORM_EXIT 7'h04
`define CXU_OP_FP_ON 10'h011
`define CXU_OP_FP_OFF 10'h012
`define CXU_DEAD_PARCEL 16'h0000
`define CXU_FL_PCI 0
`define CXU_FL_MCU 1
`define CXU_FL_FPE 2
`define CXU_FL_ORE 3
`define CXU_FL_PRE 4
`define CXU_FL_MEM 5
`define CXU_FL_IO 6
`define CXU_FL_ERX 7
`define CXU_FL_NEX 8
`define CXU_E_UNC 63
`define CXU_E_COR 62
`define CXU_SYN_FLD 61:54
`define CXU_RDM_FLD 53:52
`define CXU_BANK_FLD 51:48
`define CXU_RA_FLD 63:48
`define CXU_RHI_FLD 49:48
`define CXU_P_FLD 47:24
`define CXU_BA_FLD 45:28
`define CXU_LA_FLD 45:28
`define CXU_XA_FLD 47:40
`define CXU_VL_FLD 39:33
`define CXU_FL_FLD 32:24
`define CXU_M_FLD 27:24
`define CXU_MI_BIT 24
`endif

// [src/cxu_pkg.sv]
// types shared by the context exchange unit
package cxu_pkg;
    typedef enum logic [4:0] {
        ST_DEAD = 5'h01,
        ST_IDLE = 5'h02,
        ST_DRAIN = 5'h04,
        ST_SWAP = 5'h08,
        ST_FETCH = 5'h10
    } cxu_state_e;
    typedef struct packed {
        logic monIntr;
        logic corrMem;
        logic fpErr;
        logic uncorrMem;
        logic monitor;
    } cxu_mode_s;
    typedef struct packed {
        logic valid;
        logic uncorr;
        logic [7:0] syn;
        logic [1:0] rdMode;
        logic [21:0] addr;
    } cxu_err_s;
    typedef struct packed {
        logic pcIntr;
        logic mcuIntr;
        logic fpErr;
        logic oprRange;
        logic progRange;
        logic ioIntr;
        logic memErr;
        logic memUncorr;
        logic [7:0] memSyn;
        logic [1:0] memRdMode;
        logic [21:0] memAddr;
    } cxu_evt_s;
    typedef struct packed {
        logic req;
        logic we;
        logic [21:0] addr;
        logic [63:0] wdata;
    } cxu_mem_s;
    typedef logic [15:0][63:0] cxu_ctx_t;
    typedef struct packed {
        cxu_state_e st;
        logic [5:0] cnt;
        logic [7:0] xa;
        logic [7:0] blk;
        cxu_mode_s mode;
        logic [8:0] flags;
        cxu_err_s err;
        cxu_ctx_t ctx;
        cxu_mem_s mem;
        logic ibufInval;
        logic fetchReq;
        logic [15:0] parcel;
        logic parcelValid;
        logic intReq;
        logic exchBusy;
        logic [63:0] regRdData;
    } cxu_st_s;
endpackage : cxu_pkg

// [src/cxu_word_pack.sv]
// builds one outgoing context word from the operating state
`timescale 1ns/10ps
`default_nettype none
`include "cxu_params.svh"
module cxu_word_pack
    import cxu_pkg::*;
(
    input wire logic [3:0] wordIdx,
    input wire logic [63:0] ctxWord,
    input wire cxu_mode_s mode,
    input wire logic [8:0] flags,
    input wire logic [7:0] xa,
    input wire cxu_err_s err,
    output var logic [63:0] outWord
);
    logic errShow;

    always_comb
    begin
        // error data only when its class is enabled
        errShow = err.valid & (err.uncorr ? mode.uncorrMem : mode.corrMem);
        outWord = ctxWord;
        unique case (wordIdx)
            4'h0:
            begin
                outWord[63:48] = 16'h0000;
                if (errShow)
                begin
                    outWord[`CXU_E_UNC] = err.uncorr;
                    outWord[`CXU_E_COR] = ~err.uncorr;
                    outWord[`CXU_SYN_FLD] = err.syn;
                    outWord[`CXU_RDM_FLD] = err.rdMode;
                    outWord[`CXU_BANK_FLD] = err.addr[3:0];
                end
            end
            4'h1:
            begin
                outWord[`CXU_RA_FLD] = errShow ? err.addr[19:4] : 16'h0000;
                outWord[`CXU_MI_BIT] = mode.monIntr;
            end
            4'h2:
            begin
                outWord[`CXU_RHI_FLD] = errShow ? err.addr[21:20] : 2'h0;
                outWord[`CXU_M_FLD] = {mode.corrMem, mode.fpErr, mode.uncorrMem, mode.monitor};
            end
            4'h3:
            begin
                outWord[`CXU_XA_FLD] = xa;
                outWord[`CXU_FL_FLD] = flags;
            end
            default:
            begin
                outWord = ctxWord;
            end
        endcase
    end
endmodule : cxu_word_pack
`default_nettype wire

// [src/cxu_context_exchange_unit.sv]
// context exchange unit: flags, modes, block pointer and the exchange sequence
`timescale 1ns/10ps
`default_nettype none
`include "cxu_params.svh"
module cxu_context_exchange_unit
    import cxu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire cxu_evt_s evt,
    input wire logic issueValid,
    input wire logic [15:0] issueParcel,
    input wire logic computeBusy,
    input wire logic xaWrValid,
    input wire logic [7:0] xaWrData,
    input wire logic [63:0] memRdata,
    input wire logic [3:0] regRdIdx,
    output cxu_mem_s mem,
    output logic ibufInval,
    output logic fetchReq,
    output logic [15:0] nextParcel,
    output logic nextParcelValid,
    output logic intReq,
    output logic exchBusy,
    output logic [7:0] exchBlockPointer,
    output cxu_mode_s modeControl,
    output logic [8:0] causeFlags,
    output logic [23:0] progAddr,
    output logic [17:0] baseAddr,
    output logic [17:0] fieldLimit,
    output logic [6:0] vectorCount,
    output logic [63:0] regRdData
);
    cxu_st_s s_r;
    cxu_st_s s_nxt;
    logic [63:0] packWord;
    logic [3:0] packIdx;
    logic [3:0] capIdx;
    logic [8:0] setMask;
    logic allowMon;
    logic nonMon;
    logic errExitIns;
    logic normExitIns;
    logic memErrEn;
    logic [63:0] inWord;

    // outgoing word k is built while cnt = 2k+1
    assign packIdx = s_r.cnt[4:1];

    cxu_word_pack u_pack (
        .wordIdx(packIdx),
        .ctxWord(s_r.ctx[packIdx]),
        .mode(s_r.mode),
        .flags(s_r.flags),
        .xa(s_r.xa),
        .err(s_r.err),
        .outWord(packWord)
    );

    // event qualification, shared by the idle and exchange paths
    always_comb
    begin
        nonMon = ~s_r.mode.monitor;
        allowMon = nonMon | s_r.mode.monIntr;
        errExitIns = issueValid & ~s_r.exchBusy & (issueParcel[15:9] == `CXU_OP_ERR_EXIT);
        normExitIns = issueValid & ~s_r.exchBusy & (issueParcel[15:9] == `CXU_OP_NORM_EXIT);
        memErrEn = evt.memErr & (evt.memUncorr ? s_r.mode.uncorrMem : s_r.mode.corrMem);
        setMask = 9'h000;
        setMask[`CXU_FL_PCI] = evt.pcIntr & nonMon;
        setMask[`CXU_FL_MCU] = evt.mcuIntr & nonMon;
        setMask[`CXU_FL_FPE] = evt.fpErr & s_r.mode.fpErr & allowMon;
        setMask[`CXU_FL_ORE] = evt.oprRange & allowMon;
        setMask[`CXU_FL_PRE] = evt.progRange & allowMon;
        setMask[`CXU_FL_MEM] = memErrEn;
        setMask[`CXU_FL_IO] = evt.ioIntr & nonMon;
        setMask[`CXU_FL_ERX] = errExitIns & allowMon;
        setMask[`CXU_FL_NEX] = normExitIns & nonMon;
    end

    // word k arrives while cnt = 2k+2
    assign capIdx = 4'(s_r.cnt[4:1] - 4'h1);
    assign inWord = memRdata;

    always_comb
    begin
        s_nxt = s_r;
        s_nxt.parcelValid = 1'b0;
        s_nxt.ibufInval = 1'b0;
        s_nxt.mem.req = 1'b0;
        s_nxt.mem.we = 1'b0;
        s_nxt.regRdData = s_r.ctx[regRdIdx];
        // set wins: qualified events always merge into the flags
        s_nxt.flags = s_r.flags | setMask;
        if (evt.memErr && !s_r.err.valid)
        begin
            s_nxt.err.valid = 1'b1;
            s_nxt.err.uncorr = evt.memUncorr;
            s_nxt.err.syn = evt.memSyn;
            s_nxt.err.rdMode = evt.memRdMode;
            s_nxt.err.addr = evt.memAddr;
        end
        unique case (s_r.st)
            ST_DEAD:
            begin
                s_nxt.xa = `CXU_XA_RST;
                s_nxt.parcel = `CXU_DEAD_PARCEL;
                s_nxt.parcelValid = 1'b1;
                s_nxt.flags[`CXU_FL_MCU] = 1'b1;
                s_nxt.st = ST_IDLE;
            end
            ST_IDLE:
            begin
                // only monitor code may retarget the next exchange
                if (xaWrValid && s_r.mode.monitor)
                begin
                    s_nxt.xa = xaWrData;
                end
                if (issueValid && issueParcel[15:6] == `CXU_OP_FP_ON)
                begin
                    s_nxt.mode.fpErr = 1'b1;
                end
                else if (issueValid && issueParcel[15:6] == `CXU_OP_FP_OFF)
                begin
                    s_nxt.mode.fpErr = 1'b0;
                end
                if (s_r.intReq)
                begin
                    s_nxt.st = ST_DRAIN;
                    s_nxt.exchBusy = 1'b1;
                end
            end
            ST_DRAIN:
            begin
                // nothing of the old context may still be in flight
                if (!computeBusy)
                begin
                    s_nxt.st = ST_SWAP;
                    s_nxt.cnt = 6'h00;
                    s_nxt.blk = s_r.xa;
                    s_nxt.ibufInval = 1'b1;
                end
            end
            ST_SWAP:
            begin
                s_nxt.cnt = 6'(s_r.cnt + 6'h01);
                if (s_r.cnt < 6'h20)
                begin
                    s_nxt.mem.req = 1'b1;
                    s_nxt.mem.we = s_r.cnt[0];
                    s_nxt.mem.addr = {10'h000, s_r.blk, s_r.cnt[4:1]};
                    if (s_r.cnt[0])
                    begin
                        s_nxt.mem.wdata = packWord;
                    end
                end
                if (s_r.cnt != 6'h00 && s_r.cnt <= 6'h20 && !s_r.cnt[0])
                begin
                    // only this context word is replaced
                    s_nxt.ctx[capIdx] = inWord;
                    unique case (capIdx)
                        4'h1:
                        begin
                            s_nxt.mode.monIntr = inWord[`CXU_MI_BIT];
                        end
                        4'h2:
                        begin
                            s_nxt.mode.corrMem = inWord[27];
                            s_nxt.mode.fpErr = inWord[26];
                            s_nxt.mode.uncorrMem = inWord[25];
                            s_nxt.mode.monitor = inWord[24];
                            // error words have gone out, so the record is spent; a same-cycle error still lands
                            s_nxt.err = evt.memErr ? cxu_err_s'{1'b1, evt.memUncorr, evt.memSyn, evt.memRdMode,
                                evt.memAddr} : '0;
                        end
                        4'h3:
                        begin
                            s_nxt.xa = inWord[`CXU_XA_FLD];
                            s_nxt.flags = inWord[`CXU_FL_FLD] | setMask;
                        end
                        default:
                        begin
                            s_nxt.mode = s_nxt.mode;
                        end
                    endcase
                end
                if (s_r.cnt == 6'(`CXU_SWAP_CPS - 6'h01))
                begin
                    s_nxt.st = ST_FETCH;
                    s_nxt.cnt = 6'h00;
                    s_nxt.fetchReq = 1'b1;
                end
            end
            ST_FETCH:
            begin
                s_nxt.cnt = 6'(s_r.cnt + 6'h01);
                if (s_r.cnt == 6'(`CXU_FETCH_CPS - 6'h01))
                begin
                    s_nxt.st = ST_IDLE;
                    s_nxt.fetchReq = 1'b0;
                    s_nxt.exchBusy = 1'b0;
                end
            end
        endcase
        // a leftover flag after reload sends the idle path straight back
        s_nxt.intReq = |s_nxt.flags;
    end

    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_r <= '{
                st: ST_DEAD,
                cnt: 6'h00,
                xa: `CXU_XA_RST,
                blk: `CXU_XA_RST,
                mode: `CXU_MODE_RST,
                flags: `CXU_FLAG_RST,
                err: '0,
                ctx: '0,
                mem: '0,
                ibufInval: 1'b0,
                fetchReq: 1'b0,
                parcel: `CXU_DEAD_PARCEL,
                parcelValid: 1'b0,
                intReq: 1'b0,
                exchBusy: 1'b1,
                regRdData: 64'h0000_0000_0000_0000
            };
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign mem = s_r.mem;
    assign ibufInval = s_r.ibufInval;
    assign fetchReq = s_r.fetchReq;
    assign nextParcel = s_r.parcel;
    assign nextParcelValid = s_r.parcelValid;
    assign intReq = s_r.intReq;
    assign exchBusy = s_r.exchBusy;
    assign exchBlockPointer = s_r.xa;
    assign modeControl = s_r.mode;
    assign causeFlags = s_r.flags;
    assign progAddr = s_r.ctx[0][`CXU_P_FLD];
    assign baseAddr = s_r.ctx[1][`CXU_BA_FLD];
    assign fieldLimit = s_r.ctx[2][`CXU_LA_FLD];
    assign vectorCount = s_r.ctx[3][`CXU_VL_FLD];
    assign regRdData = s_r.regRdData;
endmodule : cxu_context_exchange_unit
`default_nettype wire

// [tb/cxu_checker.sv]
// port assertions for the context exchange unit
`timescale 1ns/10ps
`default_nettype none
`include "cxu_params.svh"
module cxu_checker
    import cxu_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic issueValid,
    input wire logic [15:0] issueParcel,
    input wire logic computeBusy,
    input wire cxu_mem_s mem,
    input wire logic ibufInval,
    input wire logic fetchReq,
    input wire logic intReq,
    input wire logic exchBusy,
    input wire cxu_mode_s modeControl,
    input wire logic [8:0] causeFlags
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // run length of fetch, too long for a repetition
    logic [4:0] fetchRun_r;
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            fetchRun_r <= 5'h00;
        else
            fetchRun_r <= fetchReq ? fetchRun_r + 5'h01 : 5'h00;
    end
    property p_swap; ibufInval |-> ##36 $rose(fetchReq); endproperty
    a_swap: assert property (p_swap) else $error("swap length wrong");
    property p_fetch; $fell(fetchReq) |-> fetchRun_r == 5'h0E; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch length wrong");
    property p_first; ibufInval |=> mem.req && !mem.we && mem.addr[3:0] == 4'h0; endproperty
    a_first: assert property (p_first) else $error("first read wrong");
    property p_rdwr; mem.req && !mem.we |=> mem.req && mem.we && mem.addr == $past(mem.addr); endproperty
    a_rdwr: assert property (p_rdwr) else $error("write not after read");
    property p_low; mem.req |-> mem.addr[21:12] == 10'h000; endproperty
    a_low: assert property (p_low) else $error("block above 4096");
    property p_drain; $rose(exchBusy) && computeBusy |=> !ibufInval; endproperty
    a_drain: assert property (p_drain) else $error("swap while busy");
    property p_req; (|causeFlags) |-> ##[0:1] intReq; endproperty
    a_req: assert property (p_req) else $error("no interrupt request");
    property p_mode; !exchBusy && !issueValid |=> $stable(modeControl); endproperty
    a_mode: assert property (p_mode) else $error("mode changed");
    property p_mon; !exchBusy && modeControl.monitor && !causeFlags[`CXU_FL_IO] |=> !causeFlags[`CXU_FL_IO];
    endproperty
    a_mon: assert property (p_mon) else $error("flag set in monitor");
    property p_nex;
        !exchBusy && !modeControl.monitor && issueValid && issueParcel[15:9] == `CXU_OP_NORM_EXIT
        |=> causeFlags[`CXU_FL_NEX];
    endproperty
    a_nex: assert property (p_nex) else $error("exit flag missing");
    c_swap: cover property (ibufInval);
    c_done: cover property ($fell(exchBusy));
    c_wr: cover property (mem.req && mem.we);
endmodule : cxu_checker
bind cxu_context_exchange_unit cxu_checker i_cxu_checker (.ref_clk, .rst_b, .issueValid, .issueParcel,
    .computeBusy, .mem, .ibufInval, .fetchReq, .intReq, .exchBusy, .modeControl, .causeFlags);
`default_nettype wire

// [tb/cxu_mem_model.sv]
// central memory model: read data one cycle after a read request
`timescale 1ns/10ps
`default_nettype none
module cxu_mem_model
    import cxu_pkg::*;
(
    input wire logic ref_clk,
    input wire cxu_mem_s mem,
    output logic [63:0] memRdata
);
    logic [63:0] words [0:4095];
    initial memRdata = 64'h0000_0000_0000_0000;
    always @(posedge ref_clk)
    begin
        // released bus toggles, so a stale word never passes for fresh data
        if (mem.req && !mem.we)
            memRdata <= words[mem.addr[11:0]];
        else
            memRdata <= ~memRdata;
        if (mem.req && mem.we)
            words[mem.addr[11:0]] <= mem.wdata;
    end
endmodule : cxu_mem_model
`default_nettype wire

// [tb/tb_context_exchange_unit.sv]
// testbench for the context exchange unit
`timescale 1ns/10ps
`default_nettype none
module tb_context_exchange_unit
    import cxu_pkg::*;
;
    logic ref_clk;
    logic rst_b;
    cxu_evt_s evt;
    logic issueValid;
    logic [15:0] issueParcel;
    logic computeBusy;
    logic xaWrValid;
    logic [7:0] xaWrData;
    logic [63:0] memRdata;
    logic [3:0] regRdIdx;
    cxu_mem_s mem;
    logic ibufInval;
    logic fetchReq;
    logic [15:0] nextParcel;
    logic nextParcelValid;
    logic intReq;
    logic exchBusy;
    logic [7:0] exchBlockPointer;
    cxu_mode_s modeControl;
    logic [8:0] causeFlags;
    logic [23:0] progAddr;
    logic [17:0] baseAddr;
    logic [17:0] fieldLimit;
    logic [6:0] vectorCount;
    logic [63:0] regRdData;
    int n_mismatch;
    int checks_done;
    cxu_context_exchange_unit i_cxu_context_exchange_unit (.ref_clk, .rst_b, .evt, .issueValid, .issueParcel,
        .computeBusy, .xaWrValid, .xaWrData, .memRdata, .regRdIdx, .mem, .ibufInval, .fetchReq, .nextParcel,
        .nextParcelValid, .intReq, .exchBusy, .exchBlockPointer, .modeControl, .causeFlags, .progAddr,
        .baseAddr, .fieldLimit, .vectorCount, .regRdData);
    cxu_mem_model i_cxu_mem_model (.ref_clk, .mem, .memRdata);
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    task automatic wait_xchg(input int maxWait);
        int n;
        int nf;
        n = 0;
        nf = 0;
        while (ibufInval !== 1'b1 && n < 300)
        begin
            step();
            n++;
        end
        chk("start delay", 1, n <= maxWait);
        n = 0;
        while (exchBusy === 1'b1 && n < 300)
        begin
            nf += (fetchReq === 1'b1);
            step();
            n++;
        end
        chk("exchange cycles", 50, n);
        chk("fetch cycles", 14, nf);
    endtask : wait_xchg
    task automatic t_deadstart();
        step();
        chk("parcel valid", 1, nextParcelValid);
        chk("parcel", 0, nextParcel);
        chk("mcu flag", 1, causeFlags[1]);
        wait_xchg(5);
        chk("out w3", 24'h00_0002, i_cxu_mem_model.words[3][47:24]);
        chk("mode", 5'h0A, modeControl);
        chk("pointer", 8'h05, exchBlockPointer);
        chk("prog", 24'h00_1234, progAddr);
        chk("base", 18'h0_0ABC, baseAddr);
        chk("limit", 18'h0_0DEF, fieldLimit);
        chk("vector count", 7'h40, vectorCount);
        chk("reg rd", 64'h0123_4567_89AB_CDEF, regRdData);
    endtask : t_deadstart
    task automatic t_memerr();
        computeBusy = 1'b1;
        evt.memErr = 1'b1;
        evt.memSyn = 8'hA5;
        evt.memRdMode = 2'b10;
        evt.memAddr = 22'h2B_CDE7;
        issueValid = 1'b1;
        issueParcel = 16'h0800;
        step();
        evt = '0;
        issueValid = 1'b0;
        chk("flags", 9'h120, causeFlags);
        chk("int req", 1, intReq);
        repeat (6)
        begin
            step();
            chk("drain hold", 0, ibufInval);
        end
        computeBusy = 1'b0;
        wait_xchg(5);
        chk("err w0", 16'h6967, i_cxu_mem_model.words[80][63:48]);
        chk("err w1", 16'hBCDE, i_cxu_mem_model.words[81][63:48]);
        chk("err w2", 2'b10, i_cxu_mem_model.words[82][49:48]);
        chk("out mode", 4'hA, i_cxu_mem_model.words[82][27:24]);
        chk("out w3", 24'h05_8120, i_cxu_mem_model.words[83][47:24]);
        wait_xchg(5);
        chk("kept flags", 24'h06_0100, i_cxu_mem_model.words[99][47:24]);
        chk("no err", 0, i_cxu_mem_model.words[96][63:48]);
        chk("mode", 5'h01, modeControl);
        chk("pointer", 8'h00, exchBlockPointer);
    endtask : t_memerr
    task automatic t_monitor();
        evt = '0;
        evt.ioIntr = 1'b1;
        evt.pcIntr = 1'b1;
        evt.mcuIntr = 1'b1;
        evt.fpErr = 1'b1;
        evt.oprRange = 1'b1;
        evt.progRange = 1'b1;
        issueValid = 1'b1;
        step();
        evt = '0;
        evt.memErr = 1'b1;
        evt.memUncorr = 1'b1;
        issueValid = 1'b0;
        step();
        evt = '0;
        step();
        chk("mon flags", 0, causeFlags);
        chk("mon req", 0, intReq);
    endtask : t_monitor
    task automatic t_fpmode(input logic [15:0] parcel, input logic [4:0] expMode);
        issueValid = 1'b1;
        issueParcel = parcel;
        step();
        issueValid = 1'b0;
        step();
        chk("fp mode", expMode, modeControl);
    endtask : t_fpmode
    initial
    begin
        n_mismatch = 0;
        checks_done = 0;
        rst_b = 1'b0;
        evt = '0;
        issueValid = 1'b0;
        issueParcel = 16'h0000;
        computeBusy = 1'b0;
        xaWrValid = 1'b0;
        xaWrData = 8'h00;
        regRdIdx = 4'h4;
        for (int i = 0; i < 4096; i++)
            i_cxu_mem_model.words[i] = 64'h0000_0000_0000_0000;
        i_cxu_mem_model.words[0] = 64'h0000_0012_3400_0000;
        i_cxu_mem_model.words[1] = 64'h0000_00AB_C000_0000;
        i_cxu_mem_model.words[2] = 64'h0000_00DE_FA00_0000;
        i_cxu_mem_model.words[3] = 64'h0000_0580_0000_0000;
        i_cxu_mem_model.words[4] = 64'h0123_4567_89AB_CDEF;
        // block 5 left with a flag set, as careless software would
        i_cxu_mem_model.words[83] = 64'h0000_0601_0000_0000;
        i_cxu_mem_model.words[98] = 64'h0000_0000_0100_0000;
        repeat (3) @(posedge ref_clk);
        #1;
        rst_b = 1'b1;
        t_deadstart();
        t_memerr();
        t_monitor();
        t_fpmode(16'h0440, 5'h05);
        t_fpmode(16'h0480, 5'h01);
        xaWrValid = 1'b1;
        xaWrData = 8'h0C;
        step();
        xaWrValid = 1'b0;
        step();
        chk("xa write", 8'h0C, exchBlockPointer);
        wrap_up();
    end
    initial
    begin
        #20000;
        n_mismatch++;
        wrap_up();
    end
endmodule : tb_context_exchange_unit
`default_nettype wire
